// file: design/licr_pkg.sv
package licr_pkg;
   localparam int          licr_addr_w     = 8;
   localparam int          licr_data_w     = 32;
   localparam logic [7:0]  licr_ictl3_addr = 8'h12;
   localparam logic [7:0]  licr_dcsel_addr = 8'h13;
   localparam logic [7:0]  licr_stat_addr  = 8'h14;
   localparam logic [7:0]  licr_ictl3_rst  = 8'h00;
   localparam logic [1:0]  licr_dcsel_rst  = 2'h0;
   localparam int          licr_full_bit   = 7;
   localparam int          licr_dial_bit   = 6;
   localparam int          licr_fjt_bit    = 5;
   localparam int          licr_drop_bit   = 4;
   localparam int          licr_offs_bit   = 2;
   localparam logic [31:0] licr_unmapped   = 32'h0000_0000;
   // DC termination target in hundredths of a volt, index {sel, off, drop}.
   typedef enum logic [1:0] {
      licr_mode_lv,
      licr_mode_japan,
      licr_mode_eu_na
   } licr_mode_t;
   typedef enum logic [1:0] {
      licr_idle,
      licr_answer
   } licr_state_t;
   localparam logic [9:0] licr_vdct_eu      = 10'h190;
   localparam logic [9:0] licr_vdct_eu_d    = 10'h15f;
   localparam logic [9:0] licr_vdct_jp      = 10'h13b;
   localparam logic [9:0] licr_vdct_jp_d    = 10'h11f;
   localparam logic [9:0] licr_vdct_lv      = 10'h109;
   localparam logic [9:0] licr_vdct_lv_d    = 10'h0f7;
   localparam logic [9:0] licr_vdct_eu_o    = 10'h0e9;
   localparam logic [9:0] licr_vdct_eu_od   = 10'h0dd;
   localparam logic [9:0] licr_vdct_jp_o    = 10'h0d2;
   localparam logic [9:0] licr_vdct_jp_od   = 10'h0c9;
   localparam logic [9:0] licr_vdct_lv_o    = 10'h0c2;
   localparam logic [9:0] licr_vdct_lv_od   = 10'h0bb;
endpackage

// file: design/licr_vdct_rom.sv
`timescale 1ns/1ps
module licr_vdct_rom (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [1:0] sel,
   input  wire logic       off,
   input  wire logic       drop,
   output logic      [9:0] vdct
);
   import licr_pkg::*;

   logic [9:0] next_vdct;

   always_comb begin
      next_vdct = licr_vdct_lv;
      if (sel[1]) begin
         case ({off, drop})
            2'h0:    next_vdct = licr_vdct_eu;
            2'h1:    next_vdct = licr_vdct_eu_d;
            2'h2:    next_vdct = licr_vdct_eu_o;
            default: next_vdct = licr_vdct_eu_od;
         endcase
      end else if (sel[0]) begin
         case ({off, drop})
            2'h0:    next_vdct = licr_vdct_jp;
            2'h1:    next_vdct = licr_vdct_jp_d;
            2'h2:    next_vdct = licr_vdct_jp_o;
            default: next_vdct = licr_vdct_jp_od;
         endcase
      end else begin
         case ({off, drop})
            2'h0:    next_vdct = licr_vdct_lv;
            2'h1:    next_vdct = licr_vdct_lv_d;
            2'h2:    next_vdct = licr_vdct_lv_o;
            default: next_vdct = licr_vdct_lv_od;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         vdct <= 10'h000;
      end else begin
         vdct <= next_vdct;
      end
   end
endmodule

// file: design/licr_top.sv
`timescale 1ns/1ps
module licr_top (
   input  wire logic                            clk,
   input  wire logic                            reset,
   input  wire logic [licr_pkg::licr_addr_w-1:0] address,
   input  wire logic                            read,
   input  wire logic                            write,
   input  wire logic [licr_pkg::licr_data_w-1:0] writedata,
   input  wire logic [3:0]                       byteenable,
   output logic      [licr_pkg::licr_data_w-1:0] readdata,
   output logic                                  waitrequest,
   output logic                                  full_scale_high,
   output logic                                  dial_headroom,
   output logic                                  force_japan_termination,
   output logic                                  dc_level_drop,
   output logic      [1:0]                       dc_termination_select,
   output logic                                  japan_active,
   output logic      [9:0]                       dc_target_cv
);
   import licr_pkg::*;

   logic [7:0]  international_control_three;
   logic [1:0]  dc_sel_reg;
   licr_state_t state;
   logic        req;
   logic [1:0]  eff_sel;
   logic [9:0]  vdct;
   logic [31:0] next_readdata;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   assign req = read | write;

   // One wait cycle per access keeps the read path registered.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state       <= licr_idle;
         waitrequest <= 1'b1;
      end else begin
         case (state)
            licr_idle: begin
               if (req) begin
                  state       <= licr_answer;
                  waitrequest <= 1'b0;
               end
            end
            licr_answer: begin
               state       <= licr_idle;
               waitrequest <= 1'b1;
            end
            default: begin
               state       <= licr_idle;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         international_control_three <= licr_ictl3_rst;
         dc_sel_reg                  <= licr_dcsel_rst;
      end else if (state == licr_idle && write && byteenable[0]) begin
         if (hit(address, licr_ictl3_addr))
            international_control_three <= writedata[7:0];
         if (hit(address, licr_dcsel_addr))
            dc_sel_reg <= writedata[1:0];
      end
   end

   always_comb begin
      next_readdata = licr_unmapped;
      if (hit(address, licr_ictl3_addr))
         next_readdata = {24'h000000, international_control_three};
      else if (hit(address, licr_dcsel_addr))
         next_readdata = {30'h00000000, dc_sel_reg};
      else if (hit(address, licr_stat_addr))
         next_readdata = {22'h000000, vdct};
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         readdata <= licr_unmapped;
      end else if (state == licr_idle && read) begin
         readdata <= next_readdata;
      end
   end

   // Force bit overrides the selector toward the Japanese characteristic.
   assign eff_sel = international_control_three[licr_fjt_bit] ?
                    2'(licr_mode_japan) : dc_sel_reg;

   licr_vdct_rom u_rom (
      .clk   (clk),
      .reset (reset),
      .sel   (eff_sel),
      .off   (international_control_three[licr_offs_bit]),
      .drop  (international_control_three[licr_drop_bit]),
      .vdct  (vdct)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         full_scale_high         <= 1'b0;
         dial_headroom           <= 1'b0;
         force_japan_termination <= 1'b0;
         dc_level_drop           <= 1'b0;
         dc_termination_select   <= 2'h0;
         japan_active            <= 1'b0;
         dc_target_cv            <= 10'h000;
      end else begin
         full_scale_high <= international_control_three[licr_full_bit];
         dial_headroom   <= international_control_three[licr_dial_bit];
         force_japan_termination <=
            international_control_three[licr_fjt_bit];
         dc_level_drop   <= international_control_three[licr_drop_bit];
         dc_termination_select <= eff_sel;
         japan_active    <= (eff_sel == 2'(licr_mode_japan));
         dc_target_cv    <= vdct;
      end
   end

   property p_reset_zero;
      @(posedge clk) $fell(reset) |-> international_control_three == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("control register not zero after reset");

   property p_full;
      @(posedge clk) disable iff (reset)
      1'b1 |=> full_scale_high ==
               $past(international_control_three[licr_full_bit]);
   endproperty
   a_full: assert property (p_full)
      else $error("full scale output does not follow its bit");

   property p_fjt;
      @(posedge clk) disable iff (reset)
      international_control_three[licr_fjt_bit] |=> japan_active;
   endproperty
   a_fjt: assert property (p_fjt)
      else $error("force bit did not select japanese termination");

   sequence s_drop_eu;
      dc_sel_reg[1] && !international_control_three[licr_fjt_bit] &&
      !international_control_three[licr_offs_bit] &&
      international_control_three[licr_drop_bit];
   endsequence
   property p_drop;
      @(posedge clk) disable iff (reset)
      s_drop_eu ##1 s_drop_eu |=> dc_target_cv == licr_vdct_eu_d;
   endproperty
   a_drop: assert property (p_drop)
      else $error("lowered target wrong in european mode");

   sequence s_wr;
      state == licr_idle && write && byteenable[0] &&
      address == licr_ictl3_addr;
   endsequence
   property p_rw;
      logic [7:0] d;
      @(posedge clk) disable iff (reset)
      (s_wr, d = writedata[7:0]) |=> international_control_three == d;
   endproperty
   a_rw: assert property (p_rw)
      else $error("written value not stored");

   // Every access takes exactly one wait cycle, so a master stalls for one cycle only.
   sequence s_take;
      state == licr_idle && req;
   endsequence

   sequence s_answer;
      !waitrequest ##1 waitrequest;
   endsequence

   property p_wait_one;
      @(posedge clk) disable iff (reset)
      s_take |=> s_answer;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("access not answered after one wait cycle");

   property p_idle_wait;
      @(posedge clk) disable iff (reset)
      state == licr_idle |-> waitrequest;
   endproperty
   a_idle_wait: assert property (p_idle_wait)
      else $error("waitrequest low while idle");

   sequence s_rd_ctl;
      state == licr_idle && read && address == licr_ictl3_addr;
   endsequence
   property p_rd_ctl;
      @(posedge clk) disable iff (reset)
      s_rd_ctl |=>
         readdata == {24'h000000, $past(international_control_three)};
   endproperty
   a_rd_ctl: assert property (p_rd_ctl)
      else $error("control register read returned wrong value");

   sequence s_rd_none;
      state == licr_idle && read && address != licr_ictl3_addr &&
      address != licr_dcsel_addr && address != licr_stat_addr;
   endsequence
   property p_rd_none;
      @(posedge clk) disable iff (reset)
      s_rd_none |=> readdata == licr_unmapped;
   endproperty
   a_rd_none: assert property (p_rd_none)
      else $error("unmapped read returned nonzero data");

   property p_be_ignore;
      @(posedge clk) disable iff (reset)
      state == licr_idle && write && !byteenable[0] |=>
         $stable(international_control_three);
   endproperty
   a_be_ignore: assert property (p_be_ignore)
      else $error("write without low lane changed the register");

   property p_sel_follow;
      @(posedge clk) disable iff (reset)
      !international_control_three[licr_fjt_bit] |=>
         dc_termination_select == $past(dc_sel_reg);
   endproperty
   a_sel_follow: assert property (p_sel_follow)
      else $error("selector not passed through without force bit");

   property p_fjt_out;
      @(posedge clk) disable iff (reset)
      1'b1 |=> force_japan_termination ==
               $past(international_control_three[licr_fjt_bit]);
   endproperty
   a_fjt_out: assert property (p_fjt_out)
      else $error("force output does not follow its bit");

   property p_drop_out;
      @(posedge clk) disable iff (reset)
      1'b1 |=> dc_level_drop ==
               $past(international_control_three[licr_drop_bit]);
   endproperty
   a_drop_out: assert property (p_drop_out)
      else $error("level drop output does not follow its bit");
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import licr_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  address = 8'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0]  byteenable = 4'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        fsh, dh, fjt, drop, ja;
   logic [1:0]  dcsel;
   logic [9:0]  cv;
   logic [31:0] q[$];
   int          err_total = 0;
   int          n_tests = 0;
   int          seed = 96;
   logic [7:0]  v;
   logic [1:0]  s, se;
   logic [9:0]  e;

   licr_top uut (.clk(clk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .full_scale_high(fsh),
      .dial_headroom(dh), .force_japan_termination(fjt),
      .dc_level_drop(drop), .dc_termination_select(dcsel),
      .japan_active(ja), .dc_target_cv(cv));

   always #5 clk = ~clk;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task summarize;
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // The request is held until waitrequest is seen low at a rising edge.
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d,
            input logic [3:0] be, input logic [31:0] exp);
      @(posedge clk);
      if (!w)
         q.push_back(exp);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      byteenable <= be;
      @(posedge clk);
      while (waitrequest !== 1'b0)
         @(posedge clk);
      read <= 1'b0;
      write <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (read && waitrequest === 1'b0) begin
         if (q.size() == 0)
            chk(readdata, 32'hdead_beef);
         else
            chk(readdata, q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      chk({fsh, dh, fjt, drop, dcsel, ja, cv, waitrequest}, 32'h1);
      bus(licr_ictl3_addr, 1'b0, 0, 4'hf, 32'h0);
      bus(8'h60, 1'b1, 32'hff, 4'hf, 0);
      bus(8'h60, 1'b0, 0, 4'hf, 32'h0);
      bus(licr_ictl3_addr, 1'b1, 32'hff, 4'he, 0);
      bus(licr_ictl3_addr, 1'b0, 0, 4'hf, 32'h0);
      for (int i = 0; i < 32; i++) begin
         s = i[1:0];
         v = 8'($random(seed));
         v[7] = v[7] & (s == 2'h2);
         v[6] = v[6] & (s == 2'h3);
         v[5] = i[2];
         v[4] = i[3];
         v[2] = i[4];
         bus(licr_dcsel_addr, 1'b1, {30'h0, s}, 4'hf, 0);
         bus(licr_ictl3_addr, 1'b1, {24'h0, v}, 4'hf, 0);
         bus(licr_ictl3_addr, 1'b0, 0, 4'hf, {24'h0, v});
         bus(licr_dcsel_addr, 1'b0, 0, 4'hf, {30'h0, s});
         repeat (3) @(posedge clk);
         se = v[5] ? 2'h1 : s;
         case ({se[1], se == 2'h1, v[2], v[4]})
            4'b1000, 4'b1100: e = licr_vdct_eu;
            4'b1001, 4'b1101: e = licr_vdct_eu_d;
            4'b1010, 4'b1110: e = licr_vdct_eu_o;
            4'b1011, 4'b1111: e = licr_vdct_eu_od;
            4'b0100: e = licr_vdct_jp;
            4'b0101: e = licr_vdct_jp_d;
            4'b0110: e = licr_vdct_jp_o;
            4'b0111: e = licr_vdct_jp_od;
            4'b0000: e = licr_vdct_lv;
            4'b0001: e = licr_vdct_lv_d;
            4'b0010: e = licr_vdct_lv_o;
            default: e = licr_vdct_lv_od;
         endcase
         chk({31'h0, fsh}, {31'h0, v[7]});
         chk({30'h0, dh, fjt}, {30'h0, v[6], v[5]});
         chk({31'h0, drop}, {31'h0, v[4]});
         chk({29'h0, dcsel, ja}, {29'h0, se, se == 2'h1});
         chk({22'h0, cv}, {22'h0, e});
         bus(licr_stat_addr, 1'b0, 0, 4'hf, {22'h0, e});
      end
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      chk({fsh, dh, fjt, drop, dcsel, ja, cv, waitrequest}, 32'h1);
      bus(licr_ictl3_addr, 1'b0, 0, 4'hf, 32'h0);
      bus(licr_dcsel_addr, 1'b0, 0, 4'hf, 32'h0);
      repeat (2) @(posedge clk);
      summarize();
   end
endmodule
